// ==== inc/scdw_pkg.sv ====
// types shared by the store unit and its helpers
// assumes scdw_regs.svh is on the include path
`include "scdw_regs.svh"

package scdw_pkg;

  typedef enum logic [2:0] {
    scdw_exc_none = `SCDW_EXC_NONE,
    scdw_exc_addr = `SCDW_EXC_ADDR,
    scdw_exc_cop_unusable = `SCDW_EXC_COP_UNUSABLE,
    scdw_exc_reserved = `SCDW_EXC_RESERVED,
    scdw_exc_tlb_refill = `SCDW_EXC_TLB_REFILL,
    scdw_exc_tlb_invalid = `SCDW_EXC_TLB_INVALID,
    scdw_exc_tlb_modified = `SCDW_EXC_TLB_MODIFIED,
    scdw_exc_watch = `SCDW_EXC_WATCH
  } scdw_exc_type;

  typedef enum logic [1:0] {
    scdw_st_idle = `SCDW_ST_IDLE,
    scdw_st_first = `SCDW_ST_FIRST,
    scdw_st_second = `SCDW_ST_SECOND
  } scdw_state_type;

endpackage

// ==== inc/scdw_regs.svh ====
// constants for the conditional word store and doubleword store unit
// assumes 32-bit instruction words and 32-bit general registers
`ifndef SCDW_REGS_SVH
`define SCDW_REGS_SVH

`define SCDW_OP_LSB 26
`define SCDW_OP_W 6
`define SCDW_OP_SC 6'h38
`define SCDW_OP_FPR_DW 6'h3d
`define SCDW_OP_COP2_DW 6'h3e
`define SCDW_OP_FPU_EXT 6'h13
`define SCDW_FUNC_FPR_IDX 6'h09
`define SCDW_FUNC_LSB 0
`define SCDW_BASE_LSB 21
`define SCDW_RT_LSB 16
`define SCDW_ZERO_LSB 6
`define SCDW_REG_W 5
`define SCDW_OFFSET_W 16

`define SCDW_HI_WORD_XOR 32'h00000004
`define SCDW_ENDIAN_LSB 2
`define SCDW_WORD_ALIGN_MASK 32'h00000003
`define SCDW_DWORD_ALIGN_MASK 32'h00000007
`define SCDW_LINK_BLOCK_BITS 4

`define SCDW_EXC_NONE 3'h0
`define SCDW_EXC_ADDR 3'h1
`define SCDW_EXC_COP_UNUSABLE 3'h2
`define SCDW_EXC_RESERVED 3'h3
`define SCDW_EXC_TLB_REFILL 3'h4
`define SCDW_EXC_TLB_INVALID 3'h5
`define SCDW_EXC_TLB_MODIFIED 3'h6
`define SCDW_EXC_WATCH 3'h7

`define SCDW_ST_IDLE 2'h0
`define SCDW_ST_FIRST 2'h1
`define SCDW_ST_SECOND 2'h3

`endif

// ==== verification/scdw_mem_model.sv ====
// write-port responder standing in for the cache and memory side
// assumes the store unit drives the port from clk; stall depth set by the bench
module scdw_mem_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic mem_wr_valid,
  input wire logic [31:0] mem_wr_addr,
  input wire logic [31:0] mem_wr_data,
  input wire logic [3:0] stall_cycles,
  output logic mem_wr_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] wr_a [8];
  logic [31:0] wr_d [8];
  int wr_n;
  int wait_n;
  initial begin
    mem_wr_ready = 1'b0;
    wr_n = 0;
    wait_n = 0;
  end
  // records each accepted address and data word in order, in an eight-entry ring that wraps
  always @(posedge clk) begin
    if (reset) begin
      mem_wr_ready <= 1'b0;
      wait_n <= 0;
    end else if (mem_wr_valid && mem_wr_ready) begin
      wr_a[wr_n[2:0]] <= mem_wr_addr;
      wr_d[wr_n[2:0]] <= mem_wr_data;
      wr_n <= wr_n + 1;
      mem_wr_ready <= 1'b0;
      wait_n <= 0;
    end else if (mem_wr_valid) begin
      // stalls stretch the hold window of addr and data
      if (wait_n >= int'(stall_cycles)) mem_wr_ready <= 1'b1;
      else wait_n <= wait_n + 1;
    end else begin
      mem_wr_ready <= 1'b0;
      wait_n <= 0;
    end
  end
endmodule

// ==== verification/store_conditional_and_dword_store_tb_top.sv ====
// self-checking bench for the conditional and doubleword store unit
// assumes scdw_pkg compiled first and the memory responder alongside
module store_conditional_and_dword_store_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, instr_ready;
  logic [31:0] instr = 32'h0, base_value = 32'h0, index_value = 32'h0, rt_value = 32'h0;
  logic [31:0] fpr_lo = 32'h11112222, fpr_hi = 32'h33334444;
  logic [31:0] cop2_lo = 32'h55556666, cop2_hi = 32'h77778888;
  logic cop1_usable = 1'b1, cop2_usable = 1'b1, big_endian_cpu = 1'b0, reverse_endian = 1'b0;
  scdw_pkg::scdw_exc_type xlat_exc = scdw_pkg::scdw_exc_none, exc_code, exc_c;
  logic load_linked_exec = 1'b0, exception_return_exec = 1'b0, remote_store_valid = 1'b0;
  logic [31:0] load_linked_addr = 32'h0, remote_store_addr = 32'h0;
  logic mem_wr_valid, mem_wr_ready, gpr_wr_valid, store_done, exc_valid;
  logic [31:0] mem_wr_addr, mem_wr_data, gpr_wr_data, gpr_d;
  logic [4:0] gpr_wr_index, gpr_i;
  logic [3:0] stall = 4'h0;
  int n_fail = 0, cmp_count = 0, gpr_n = 0, exc_n = 0, done_n = 0;

  always #2.5 clk = ~clk;

  scdw_store_unit i_scdw_store_unit (.clk(clk), .reset(reset), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .base_value(base_value),
    .index_value(index_value), .rt_value(rt_value), .fpr_lo(fpr_lo), .fpr_hi(fpr_hi),
    .cop2_lo(cop2_lo), .cop2_hi(cop2_hi), .cop1_usable(cop1_usable),
    .cop2_usable(cop2_usable), .big_endian_cpu(big_endian_cpu),
    .reverse_endian(reverse_endian), .xlat_exc(xlat_exc),
    .load_linked_exec(load_linked_exec), .load_linked_addr(load_linked_addr),
    .exception_return_exec(exception_return_exec), .remote_store_valid(remote_store_valid),
    .remote_store_addr(remote_store_addr), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .gpr_wr_valid(gpr_wr_valid), .gpr_wr_index(gpr_wr_index), .gpr_wr_data(gpr_wr_data),
    .store_done(store_done), .exc_valid(exc_valid), .exc_code(exc_code));

  scdw_mem_model i_scdw_mem_model (.clk(clk), .reset(reset), .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .stall_cycles(stall),
    .mem_wr_ready(mem_wr_ready));

  // one-cycle pulses are caught here so no task has to sit on the right edge
  always @(posedge clk) begin
    if (gpr_wr_valid === 1'b1) begin
      gpr_n = gpr_n + 1;
      gpr_d = gpr_wr_data;
      gpr_i = gpr_wr_index;
    end
    if (exc_valid === 1'b1) begin
      exc_n = exc_n + 1;
      exc_c = exc_code;
    end
    if (store_done === 1'b1) done_n = done_n + 1;
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // kind 1 load linked, 2 remote coherent store, 3 exception return
  task automatic pulse(input int kind, input logic [31:0] a);
    @(negedge clk);
    load_linked_exec = (kind == 1);
    remote_store_valid = (kind == 2);
    exception_return_exec = (kind == 3);
    load_linked_addr = a;
    remote_store_addr = a;
    @(negedge clk);
    {load_linked_exec, remote_store_valid, exception_return_exec} = 3'h0;
  endtask

  task automatic exec(input logic [31:0] ins, input logic [31:0] b, input logic [31:0] x,
                      input logic [31:0] r);
    int k;
    k = 0;
    @(negedge clk);
    while (instr_ready !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    if (k == 50) begin
      n_fail++;
      report_and_stop();
    end
    gpr_n = 0;
    exc_n = 0;
    done_n = 0;
    {instr, base_value, index_value, rt_value} = {ins, b, x, r};
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    k = 0;
    while (gpr_n + exc_n + done_n == 0 && k < 60) begin
      @(negedge clk);
      k++;
    end
    if (k == 60) begin
      n_fail++;
      report_and_stop();
    end
    // a short tail shows up any stray second pulse or write
    repeat (3) @(negedge clk);
  endtask

  // evt 0 no link, 1 link, 2 link then remote store at ea, 3 link then return
  task automatic sc_case(input logic [31:0] b, input logic [15:0] off, input int evt,
                         input logic [31:0] ea, input logic ok);
    logic [31:0] eff;
    int w0;
    eff = b + {{16{off[15]}}, off};
    if (evt > 0) pulse(1, eff);
    if (evt == 2) pulse(2, ea);
    if (evt == 3) pulse(3, 32'h0);
    w0 = i_scdw_mem_model.wr_n;
    exec({6'h38, 5'h03, 5'h07, off}, b, 32'h0, 32'hcafe0001);
    chk(gpr_n, 32'h1);
    chk({27'h0, gpr_i}, 32'h7);
    chk(gpr_d, {31'h0, ok});
    chk(exc_n, 32'h0);
    chk(i_scdw_mem_model.wr_n - w0, {31'h0, ok});
    if (ok) chk(i_scdw_mem_model.wr_a[w0[2:0]], eff);
    if (ok) chk(i_scdw_mem_model.wr_d[w0[2:0]], 32'hcafe0001);
    $display("test conditional store case %0d done", evt);
  endtask

  task automatic dw_case(input int kind, input logic be, input logic re);
    logic [31:0] ins, eff, a0, b, x, lo, hi;
    int w0;
    b = 32'h00001000;
    x = 32'h00000238;
    {big_endian_cpu, reverse_endian} = {be, re};
    case (kind)
      0: {ins, eff, lo, hi} = {{6'h3d, 5'h02, 5'h04, 16'hfff8}, b - 32'h8, fpr_lo, fpr_hi};
      1: {ins, eff, lo, hi} = {{6'h3e, 5'h02, 5'h04, 16'h0010}, b + 32'h10, cop2_lo, cop2_hi};
      default: {ins, eff, lo, hi} = {{6'h13, 5'h02, 5'h05, 5'h04, 5'h00, 6'h09}, b + x,
                                     fpr_lo, fpr_hi};
    endcase
    a0 = eff ^ {29'h0, be ^ re, 2'h0};
    w0 = i_scdw_mem_model.wr_n;
    exec(ins, b, x, 32'h0);
    chk(done_n, 32'h1);
    chk(i_scdw_mem_model.wr_n - w0, 32'h2);
    chk(i_scdw_mem_model.wr_a[w0[2:0]], a0);
    chk(i_scdw_mem_model.wr_a[w0[2:0] + 3'h1], a0 ^ 32'h4);
    chk(i_scdw_mem_model.wr_d[w0[2:0]], lo);
    chk(i_scdw_mem_model.wr_d[w0[2:0] + 3'h1], hi);
    $display("test doubleword kind %0d endian %0d%0d done", kind, be, re);
  endtask

  task automatic flt_case(input logic [31:0] ins, input logic [31:0] b, input logic c1,
                          input logic c2, input scdw_pkg::scdw_exc_type xl,
                          input scdw_pkg::scdw_exc_type exp);
    int w0;
    {cop1_usable, cop2_usable} = {c1, c2};
    xlat_exc = xl;
    w0 = i_scdw_mem_model.wr_n;
    exec(ins, b, 32'h00000001, 32'h0);
    chk(exc_n, 32'h1);
    chk({29'h0, exc_c}, {29'h0, exp});
    chk(i_scdw_mem_model.wr_n - w0, 32'h0);
    chk(gpr_n, 32'h0);
    {cop1_usable, cop2_usable} = {1'b1, 1'b1};
    xlat_exc = scdw_pkg::scdw_exc_none;
    $display("test fault case code %0d done", exp);
  endtask

  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    sc_case(32'h00002000, 16'h0040, 1, 32'h0, 1'b1);
    sc_case(32'h00002000, 16'hfff0, 1, 32'h0, 1'b1);
    stall = 4'h3;
    sc_case(32'h00002000, 16'h0004, 2, 32'h0000200c, 1'b0);
    sc_case(32'h00002000, 16'h0004, 2, 32'h00002010, 1'b1);
    sc_case(32'h00002000, 16'h0008, 3, 32'h0, 1'b0);
    stall = 4'h4;
    for (int k = 0; k < 3; k++) begin
      for (int e = 0; e < 4; e++) dw_case(k, e[1], e[0]);
    end
    flt_case({6'h38, 5'h01, 5'h07, 16'h0000}, 32'h00001002, 1'b1, 1'b1,
             scdw_pkg::scdw_exc_none, scdw_pkg::scdw_exc_addr);
    flt_case({6'h3d, 5'h01, 5'h04, 16'h0000}, 32'h00001004, 1'b1, 1'b1,
             scdw_pkg::scdw_exc_none, scdw_pkg::scdw_exc_addr);
    flt_case({6'h3e, 5'h01, 5'h04, 16'h0000}, 32'h00001001, 1'b1, 1'b1,
             scdw_pkg::scdw_exc_none, scdw_pkg::scdw_exc_addr);
    flt_case({6'h13, 5'h01, 5'h05, 5'h01, 5'h04, 6'h09}, 32'h00001000, 1'b1, 1'b1,
             scdw_pkg::scdw_exc_none, scdw_pkg::scdw_exc_reserved);
    flt_case({6'h3d, 5'h01, 5'h04, 16'h0000}, 32'h00001000, 1'b0, 1'b1,
             scdw_pkg::scdw_exc_none, scdw_pkg::scdw_exc_cop_unusable);
    flt_case({6'h3e, 5'h01, 5'h04, 16'h0000}, 32'h00001000, 1'b1, 1'b0,
             scdw_pkg::scdw_exc_none, scdw_pkg::scdw_exc_cop_unusable);
    for (int c = 4; c < 8; c++) begin
      flt_case({6'h3d, 5'h01, 5'h04, 16'h0000}, 32'h00001000, 1'b1, 1'b1,
               scdw_pkg::scdw_exc_type'(c), scdw_pkg::scdw_exc_type'(c));
    end
    report_and_stop();
  end
endmodule

// ==== verilog/scdw_addr_gen.sv ====
// effective address adder with alignment check
// assumes operands are stable in the cycle the instruction is taken
`include "scdw_regs.svh"
module scdw_addr_gen (
  input wire logic [31:0] base_value,
  input wire logic [31:0] addend,
  input wire logic dword,
  output logic [31:0] eff_addr,
  output logic misaligned
);

  always_comb begin
    eff_addr = base_value + addend;
    // word needs two clear low bits, doubleword three
    if (dword) begin
      misaligned = |(eff_addr & `SCDW_DWORD_ALIGN_MASK);
    end else begin
      misaligned = |(eff_addr & `SCDW_WORD_ALIGN_MASK);
    end
  end

endmodule

// ==== verilog/scdw_link_tracker.sv ====
// link flag and linked block address for conditional stores
// assumes all event pulses come from logic on clk
`include "scdw_regs.svh"
module scdw_link_tracker #(
  parameter int BLOCK_BITS = `SCDW_LINK_BLOCK_BITS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_set,
  input wire logic [31:0] link_addr,
  input wire logic remote_store_valid,
  input wire logic [31:0] remote_store_addr,
  input wire logic exception_return,
  input wire logic consume,
  output logic link_flag
);

  logic [31:0] block_addr;
  logic [31:0] next_block_addr;
  logic next_link_flag;
  logic block_hit;

  always_comb begin
    block_hit = remote_store_valid &&
      (remote_store_addr[31:BLOCK_BITS] == block_addr[31:BLOCK_BITS]);
    next_block_addr = link_set ? link_addr : block_addr;
    // a new link wins over any clearing event in the same cycle
    if (link_set) begin
      next_link_flag = 1'b1;
    end else if (block_hit || exception_return || consume) begin
      next_link_flag = 1'b0;
    end else begin
      next_link_flag = link_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link_flag <= 1'b0;
      block_addr <= 32'h0;
    end else begin
      link_flag <= next_link_flag;
      block_addr <= next_block_addr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  remote_clears_a:
  assert property (block_hit && !link_set |=> !link_flag)
    else $error("remote store into linked block left link flag set");
  exception_return_clears_a:
  assert property (exception_return && !link_set |=> !link_flag)
    else $error("exception return left link flag set");
  link_sets_a:
  assert property (link_set |=> link_flag && block_addr == $past(link_addr))
    else $error("load linked did not set link flag");

endmodule

// ==== verilog/scdw_store_unit.sv ====
// conditional word store and doubleword store execution unit
// assumes pipeline supplies register values, translated address faults
// and a memory write port with valid/ready handshake, all on clk
`include "scdw_regs.svh"
module scdw_store_unit #(
  parameter int BLOCK_BITS = `SCDW_LINK_BLOCK_BITS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  output logic instr_ready,
  input wire logic [31:0] base_value,
  input wire logic [31:0] index_value,
  input wire logic [31:0] rt_value,
  input wire logic [31:0] fpr_lo,
  input wire logic [31:0] fpr_hi,
  input wire logic [31:0] cop2_lo,
  input wire logic [31:0] cop2_hi,
  input wire logic cop1_usable,
  input wire logic cop2_usable,
  input wire logic big_endian_cpu,
  input wire logic reverse_endian,
  input wire scdw_pkg::scdw_exc_type xlat_exc,
  input wire logic load_linked_exec,
  input wire logic [31:0] load_linked_addr,
  input wire logic exception_return_exec,
  input wire logic remote_store_valid,
  input wire logic [31:0] remote_store_addr,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [31:0] mem_wr_addr,
  output logic [31:0] mem_wr_data,
  output logic gpr_wr_valid,
  output logic [4:0] gpr_wr_index,
  output logic [31:0] gpr_wr_data,
  output logic store_done,
  output logic exc_valid,
  output scdw_pkg::scdw_exc_type exc_code
);

  scdw_pkg::scdw_state_type state;
  scdw_pkg::scdw_state_type next_state;
  logic next_instr_ready;
  logic next_mem_wr_valid;
  logic [31:0] next_mem_wr_addr;
  logic [31:0] next_mem_wr_data;
  logic next_gpr_wr_valid;
  logic [4:0] next_gpr_wr_index;
  logic [31:0] next_gpr_wr_data;
  logic next_store_done;
  logic next_exc_valid;
  scdw_pkg::scdw_exc_type next_exc_code;
  logic [31:0] hi_data;
  logic [31:0] next_hi_data;
  logic sc_pending;
  logic next_sc_pending;

  logic [5:0] opcode;
  logic is_sc;
  logic is_fpr_dw;
  logic is_cop2_dw;
  logic is_fpr_idx;
  logic is_dword;
  logic accept;
  logic [31:0] offset_ext;
  logic [31:0] addend;
  logic [31:0] eff_addr;
  logic misaligned;
  logic [31:0] endian_term;
  scdw_pkg::scdw_exc_type cand_exc;
  logic link_flag;
  logic link_consume;
  logic mem_take;

  always_comb begin
    opcode = instr[`SCDW_OP_LSB +: `SCDW_OP_W];
    is_sc = (opcode == `SCDW_OP_SC);
    is_fpr_dw = (opcode == `SCDW_OP_FPR_DW);
    is_cop2_dw = (opcode == `SCDW_OP_COP2_DW);
    is_fpr_idx = (opcode == `SCDW_OP_FPU_EXT) &&
      (instr[`SCDW_FUNC_LSB +: `SCDW_OP_W] == `SCDW_FUNC_FPR_IDX);
    is_dword = is_fpr_dw || is_cop2_dw || is_fpr_idx;
    // foreign encodings are left for other units, never taken here
    accept = instr_valid && instr_ready && (is_sc || is_dword);
    offset_ext = {{16{instr[`SCDW_OFFSET_W - 1]}}, instr[`SCDW_OFFSET_W - 1:0]};
    addend = is_fpr_idx ? index_value : offset_ext;
    endian_term = {29'h0, big_endian_cpu ^ reverse_endian, 2'h0};
    mem_take = mem_wr_valid && mem_wr_ready;
  end

  scdw_addr_gen u_addr_gen (
    .base_value(base_value),
    .addend(addend),
    .dword(is_dword),
    .eff_addr(eff_addr),
    .misaligned(misaligned)
  );

  scdw_link_tracker #(
    .BLOCK_BITS(BLOCK_BITS)
  ) u_link (
    .clk(clk),
    .reset(reset),
    .link_set(load_linked_exec),
    .link_addr(load_linked_addr),
    .remote_store_valid(remote_store_valid),
    .remote_store_addr(remote_store_addr),
    .exception_return(exception_return_exec),
    .consume(link_consume),
    .link_flag(link_flag)
  );

  // fault priority: unusable, reserved, alignment, then translation
  always_comb begin
    if ((is_fpr_dw || is_fpr_idx) && !cop1_usable) begin
      cand_exc = scdw_pkg::scdw_exc_cop_unusable;
    end else if (is_cop2_dw && !cop2_usable) begin
      cand_exc = scdw_pkg::scdw_exc_cop_unusable;
    end else if (is_fpr_idx && (instr[`SCDW_ZERO_LSB +: `SCDW_REG_W] != 5'h0)) begin
      cand_exc = scdw_pkg::scdw_exc_reserved;
    end else if (misaligned) begin
      cand_exc = scdw_pkg::scdw_exc_addr;
    end else begin
      cand_exc = xlat_exc;
    end
  end

  always_comb begin
    next_state = state;
    next_mem_wr_valid = mem_wr_valid;
    next_mem_wr_addr = mem_wr_addr;
    next_mem_wr_data = mem_wr_data;
    next_hi_data = hi_data;
    next_sc_pending = sc_pending;
    next_gpr_wr_valid = 1'b0;
    next_gpr_wr_index = gpr_wr_index;
    next_gpr_wr_data = gpr_wr_data;
    next_store_done = 1'b0;
    next_exc_valid = 1'b0;
    next_exc_code = exc_code;
    link_consume = 1'b0;
    case (state)
      scdw_pkg::scdw_st_idle: begin
        if (accept) begin
          if (cand_exc != scdw_pkg::scdw_exc_none) begin
            next_exc_valid = 1'b1;
            next_exc_code = cand_exc;
          end else if (is_sc) begin
            // flag sampled here; a later remote store cannot undo an issued write
            // local accesses between link and this store do not clear it
            link_consume = 1'b1;
            if (link_flag) begin
              next_mem_wr_valid = 1'b1;
              next_mem_wr_addr = eff_addr;
              next_mem_wr_data = rt_value;
              next_gpr_wr_index = instr[`SCDW_RT_LSB +: `SCDW_REG_W];
              next_sc_pending = 1'b1;
              next_state = scdw_pkg::scdw_st_first;
            end else begin
              next_gpr_wr_valid = 1'b1;
              next_gpr_wr_index = instr[`SCDW_RT_LSB +: `SCDW_REG_W];
              next_gpr_wr_data = {31'h0, link_flag};
            end
          end else begin
            next_mem_wr_valid = 1'b1;
            next_mem_wr_addr = eff_addr ^ endian_term;
            next_mem_wr_data = is_cop2_dw ? cop2_lo : fpr_lo;
            next_hi_data = is_cop2_dw ? cop2_hi : fpr_hi;
            next_sc_pending = 1'b0;
            next_state = scdw_pkg::scdw_st_first;
          end
        end
      end
      scdw_pkg::scdw_st_first: begin
        if (mem_take) begin
          if (sc_pending) begin
            next_mem_wr_valid = 1'b0;
            next_gpr_wr_valid = 1'b1;
            next_gpr_wr_data = {31'h0, 1'b1};
            next_store_done = 1'b1;
            next_sc_pending = 1'b0;
            next_state = scdw_pkg::scdw_st_idle;
          end else begin
            next_mem_wr_addr = mem_wr_addr ^ `SCDW_HI_WORD_XOR;
            next_mem_wr_data = hi_data;
            next_state = scdw_pkg::scdw_st_second;
          end
        end
      end
      scdw_pkg::scdw_st_second: begin
        if (mem_take) begin
          next_mem_wr_valid = 1'b0;
          next_store_done = 1'b1;
          next_state = scdw_pkg::scdw_st_idle;
        end
      end
      default: begin
        next_mem_wr_valid = 1'b0;
        next_sc_pending = 1'b0;
        next_state = scdw_pkg::scdw_st_idle;
      end
    endcase
    next_instr_ready = (next_state == scdw_pkg::scdw_st_idle);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= scdw_pkg::scdw_st_idle;
      instr_ready <= 1'b0;
      mem_wr_valid <= 1'b0;
      mem_wr_addr <= 32'h0;
      mem_wr_data <= 32'h0;
      hi_data <= 32'h0;
      sc_pending <= 1'b0;
      gpr_wr_valid <= 1'b0;
      gpr_wr_index <= 5'h0;
      gpr_wr_data <= 32'h0;
      store_done <= 1'b0;
      exc_valid <= 1'b0;
      exc_code <= scdw_pkg::scdw_exc_none;
    end else begin
      state <= next_state;
      instr_ready <= next_instr_ready;
      mem_wr_valid <= next_mem_wr_valid;
      mem_wr_addr <= next_mem_wr_addr;
      mem_wr_data <= next_mem_wr_data;
      hi_data <= next_hi_data;
      sc_pending <= next_sc_pending;
      gpr_wr_valid <= next_gpr_wr_valid;
      gpr_wr_index <= next_gpr_wr_index;
      gpr_wr_data <= next_gpr_wr_data;
      store_done <= next_store_done;
      exc_valid <= next_exc_valid;
      exc_code <= next_exc_code;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sc_decode_a:
  assert property (instr_valid && instr_ready && opcode == `SCDW_OP_SC |=>
    (exc_valid || gpr_wr_valid || mem_wr_valid))
    else $error("conditional store encoding not taken");
  sc_address_a:
  assert property (accept && is_sc && cand_exc == scdw_pkg::scdw_exc_none && link_flag |=>
    mem_wr_valid && mem_wr_addr == $past(base_value) + $past(offset_ext))
    else $error("conditional store address wrong");
  sc_misalign_a:
  assert property (accept && is_sc && eff_addr[1:0] != 2'h0 |=>
    exc_valid && exc_code == scdw_pkg::scdw_exc_addr && !mem_wr_valid)
    else $error("misaligned conditional store not faulted");
  sc_success_a:
  assert property (state == scdw_pkg::scdw_st_first && sc_pending && mem_take |=>
    gpr_wr_valid && gpr_wr_data == 32'h1 && !mem_wr_valid && instr_ready)
    else $error("successful conditional store did not return one");
  sc_fail_a:
  assert property (accept && is_sc && cand_exc == scdw_pkg::scdw_exc_none && !link_flag |=>
    gpr_wr_valid && gpr_wr_data == 32'h0 && !mem_wr_valid ##1 (!mem_wr_valid || $past(accept)))
    else $error("failed conditional store wrote memory or nonzero");
  sc_flag_gate_a:
  assert property (accept && is_sc && cand_exc == scdw_pkg::scdw_exc_none |=>
    mem_wr_valid == $past(link_flag) && (mem_wr_data == $past(rt_value) || !$past(link_flag)))
    else $error("conditional store issued against link flag");
  dw_lo_data_a:
  assert property (accept && is_fpr_dw && cand_exc == scdw_pkg::scdw_exc_none |=>
    mem_wr_valid && mem_wr_data == $past(fpr_lo) && state == scdw_pkg::scdw_st_first)
    else $error("float doubleword low word wrong");
  cop2_lo_data_a:
  assert property (accept && is_cop2_dw && cand_exc == scdw_pkg::scdw_exc_none |=>
    mem_wr_valid && mem_wr_data == $past(cop2_lo))
    else $error("coprocessor doubleword low word wrong");
  idx_reserved_a:
  assert property (accept && is_fpr_idx && cop1_usable &&
    instr[`SCDW_ZERO_LSB +: `SCDW_REG_W] != 5'h0 |=>
    exc_valid && exc_code == scdw_pkg::scdw_exc_reserved)
    else $error("indexed store with nonzero field not reserved");
  dw_misalign_a:
  assert property (accept && is_dword && eff_addr[2:0] != 3'h0 |=>
    exc_valid && !mem_wr_valid && exc_code != scdw_pkg::scdw_exc_none)
    else $error("misaligned doubleword not faulted");
  dw_second_word_a:
  assert property (state == scdw_pkg::scdw_st_first && !sc_pending && mem_take |=>
    mem_wr_valid && mem_wr_addr == ($past(mem_wr_addr) ^ `SCDW_HI_WORD_XOR) &&
    mem_wr_data == $past(hi_data))
    else $error("second doubleword word wrong");
  dw_unusable_a:
  assert property (accept && is_cop2_dw && !cop2_usable |=>
    exc_valid && exc_code == scdw_pkg::scdw_exc_cop_unusable && instr_ready)
    else $error("coprocessor unusable not raised");

  sc_success_c: cover property (accept && is_sc && link_flag ##[1:20] gpr_wr_valid);
  sc_fail_c: cover property (accept && is_sc && !link_flag ##1 gpr_wr_valid);
  dw_done_c: cover property (accept && is_dword ##[2:20] store_done);
  addr_fault_c: cover property (exc_valid && exc_code == scdw_pkg::scdw_exc_addr);

endmodule
